// ===== hdl/phy_cfg_pkg.sv
package phy_cfg_pkg;

   // bus geometry: byte address, one word per register
   localparam int          ADDR_W        = 10;
   localparam int          DATA_W        = 32;

   // register indices; byte address is four times the index
   localparam logic [7:0]  IDX_EN_SET    = 8'h8C;
   localparam logic [7:0]  IDX_EN_CLR    = 8'h8D;
   localparam logic [7:0]  IDX_CFG       = 8'h8E;
   localparam logic [7:0]  IDX_IRQ_STAT  = 8'hA0;
   localparam logic [7:0]  IDX_IRQ_MASK  = 8'hA1;
   localparam logic [7:0]  IDX_DETECT    = 8'hA2;

   // shared enable register: reset value and writable bits
   localparam logic [7:0]  EN_RESET      = 8'h40;
   localparam logic [7:0]  EN_WMASK      = 8'h7F;
   localparam int          EN_RESUME     = 6;
   localparam int          EN_ID_OPEN    = 5;
   localparam int          EN_ID_RES     = 4;
   localparam int          EN_SESS_TMR   = 3;
   localparam int          EN_VBUS_RISE  = 2;
   localparam int          EN_VBUS_FALL  = 1;
   localparam int          EN_BATT       = 0;

   // adapter and frame clock configuration
   localparam logic [7:0]  CFG_RESET     = 8'h00;
   localparam int          CFG_B         = 7;
   localparam int          CFG_A         = 6;
   localparam int          CFG_SOF       = 5;

   // interrupt status and mask layout
   localparam int          IRQ_W         = 6;
   localparam logic [5:0]  IRQ_RESET     = 6'h00;
   localparam int          IRQ_ID_OPEN   = 0;
   localparam int          IRQ_ID_RES    = 1;
   localparam int          IRQ_VBUS_RISE = 2;
   localparam int          IRQ_VBUS_FALL = 3;
   localparam int          IRQ_BATT      = 4;
   localparam int          IRQ_SESS_TMR  = 5;

   // raw detector levels arriving from the analog side
   typedef struct packed {
      logic id_float;
      logic adapter_a_resistance;
      logic adapter_b_resistance;
      logic a_side_vbus_valid;
      logic session_valid;
      logic id_grounded;
      logic vbus_monitor;
      logic battery_monitor;
      logic session_timer_timeout;
   } detect_pins_t;

   // commands and strobes from the link-side logic, same clock
   typedef struct packed {
      logic vbus_charge_cmd;
      logic vbus_discharge_cmd;
      logic drive_vbus_cmd;
      logic hs_sof_strobe;
      logic resume_k_detect;
   } link_cmd_t;

   // line-state bits placed into receive command bytes
   typedef struct packed {
      logic a_side_vbus_valid;
      logic session_valid;
      logic id_grounded;
      logic alt_int;
   } rxcmd_report_t;

endpackage : phy_cfg_pkg

// ===== hdl/level_sync.sv
`timescale 1ns/100ps
// two-stage synchroniser for a bundle of independent levels
module level_sync #(
   parameter int WIDTH = 1
) (
   input  wire logic             ref_clk,
   input  wire logic             rstn,
   input  wire logic [WIDTH-1:0] async_in,
   output logic      [WIDTH-1:0] sync_out
);

   logic [WIDTH-1:0] meta;   // first stage, read only by the second

   // each bit crosses alone; no multi-bit coherence is promised
   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         meta     <= '0;
         sync_out <= '0;
      end else begin
         meta     <= async_in;
         sync_out <= meta;
      end
   end

endmodule : level_sync

// ===== hdl/adapter_frame_regs.sv
// Design decision made here: the Avalon-MM slave port.
`timescale 1ns/100ps
// Overview of operation
// RQ1: enable set access at index 8C, seven bits
// RQ2: enable clear access at index 8D, same layout
// RQ3: ones set or clear; both read enable
// RQ4: config register at 8E, resets zero
// RQ5: B adapter masks VBUS plug detection forwarding
// RQ6: B adapter reports VBUS and session zero
// RQ7: B adapter disables SRP pulls, commands kept
// RQ8: B config off leaves VBUS reporting alone
// RQ9: A adapter reports ID as grounded
// RQ10: A adapter deasserts power switch output
// RQ11: A config off changes nothing
// RQ12: frame clock driven only when enabled
// RQ13: frame clock toggles per HS SOF
// RQ14: ID float transition sends receive command
// RQ15: adapter resistance sends alt_int receive command
// RQ16: watchdog starts on resume K when enabled
module adapter_frame_regs (
   // clock and reset
   input  wire logic                        ref_clk,
   input  wire logic                        rstn,
   // register bus
   input  wire logic [phy_cfg_pkg::ADDR_W-1:0] avs_address,
   input  wire logic                        avs_read,
   input  wire logic                        avs_write,
   input  wire logic [phy_cfg_pkg::DATA_W-1:0] avs_writedata,
   output logic      [phy_cfg_pkg::DATA_W-1:0] avs_readdata,
   output logic                             avs_waitrequest,
   // analog detectors and link commands
   input  wire phy_cfg_pkg::detect_pins_t   detect_pins,
   input  wire phy_cfg_pkg::link_cmd_t      link_cmd,
   // toward link and pins
   output phy_cfg_pkg::rxcmd_report_t       rxcmd_report,
   output logic                             rxcmd_send,
   output logic                             srp_pullup,
   output logic                             srp_pulldown,
   output logic                             power_switch_out,
   output logic                             sof_clock_out,
   output logic                             resume_watchdog_start,
   output logic                             irq
);

   // whole state of the block
   typedef struct packed {
      // bus side
      logic                          waitrequest;
      logic [31:0]                   readdata;
      // software registers
      logic [7:0]                    enable;
      logic [7:0]                    cfg;
      logic [5:0]                    irq_status;
      logic [5:0]                    irq_mask;
      // detector history, outputs
      phy_cfg_pkg::detect_pins_t     pins_q;
      phy_cfg_pkg::rxcmd_report_t    report;
      logic                          rxcmd_send;
      logic                          srp_pullup;
      logic                          srp_pulldown;
      logic                          power_switch_out;
      logic                          sof_clock_out;
      logic                          resume_start;
      logic                          irq;
   } state_t;
   // every output is a bit of cur

   state_t                      cur;         // registered state
   state_t                      next_state;  // value for next edge
   phy_cfg_pkg::detect_pins_t   pins;        // synchronised detectors
   // bus decode
   logic                        req;         // read or write pending
   logic                        wr_take;     // write committed this edge
   // adapter and event terms
   logic                        bmask;       // B adapter condition
   logic                        amask;       // A adapter condition
   logic                        open_evt;    // ID float edge, enabled
   logic                        res_evt;     // resistor change, enabled
   logic [5:0]                  events;      // enabled interrupt events
   logic [5:0]                  clr_bits;    // write-one-to-clear bits
   phy_cfg_pkg::rxcmd_report_t  rep;         // report being built

   // register index from a byte address
   function automatic logic [7:0] reg_index(input logic [9:0] addr);
      reg_index = addr[9:2];
   endfunction : reg_index

   // detector levels come from another domain
   // width follows the struct
   level_sync #(
      .WIDTH ($bits(phy_cfg_pkg::detect_pins_t))
   ) u_sync (
      .ref_clk  (ref_clk),
      .rstn     (rstn),
      .async_in (detect_pins),
      .sync_out (pins)
   );

   // next-state logic for bus, events, report and pins
   always_comb begin
      // default: hold state
      next_state = cur;
      req        = avs_read | avs_write;
      wr_take    = avs_write & ~cur.waitrequest;
      clr_bits   = 6'h00;

      // one wait cycle per access; read data loaded while waiting
      next_state.waitrequest = ~(req & cur.waitrequest);
      if (req & cur.waitrequest) begin
         unique case (reg_index(avs_address))
            // same bits at both
            phy_cfg_pkg::IDX_EN_SET,
            phy_cfg_pkg::IDX_EN_CLR: begin
               next_state.readdata = {24'h000000, cur.enable}; // RQ3
            end
            // config byte
            phy_cfg_pkg::IDX_CFG: begin
               next_state.readdata = {24'h000000, cur.cfg};
            end
            // sticky events
            phy_cfg_pkg::IDX_IRQ_STAT: begin
               next_state.readdata = {26'h0000000, cur.irq_status};
            end
            // mask
            phy_cfg_pkg::IDX_IRQ_MASK: begin
               next_state.readdata = {26'h0000000, cur.irq_mask};
            end
            // synced levels
            phy_cfg_pkg::IDX_DETECT: begin
               next_state.readdata = {23'h000000, pins};
            end
            // unmapped reads answer zero
            default: begin
               next_state.readdata = 32'h00000000;
            end
         endcase
      end

      // writes land at the edge where the master sees waitrequest low
      if (wr_take) begin
         unique case (reg_index(avs_address))
            // ones set bits
            phy_cfg_pkg::IDX_EN_SET: begin
               next_state.enable = cur.enable | (avs_writedata[7:0] & phy_cfg_pkg::EN_WMASK); // RQ1
            end
            // ones clear bits
            phy_cfg_pkg::IDX_EN_CLR: begin
               next_state.enable = cur.enable & ~(avs_writedata[7:0] & phy_cfg_pkg::EN_WMASK); // RQ2
            end
            // all bits stored
            phy_cfg_pkg::IDX_CFG: begin
               next_state.cfg = avs_writedata[7:0]; // RQ4
            end
            // one clears
            phy_cfg_pkg::IDX_IRQ_STAT: begin
               clr_bits = avs_writedata[5:0];
            end
            // mask store
            phy_cfg_pkg::IDX_IRQ_MASK: begin
               next_state.irq_mask = avs_writedata[5:0];
            end
            // unmapped or read-only: write dropped
            default: begin
               clr_bits = 6'h00;
            end
         endcase
      end

      // adapter conditions need both the config bit and the detector
      bmask = cur.cfg[phy_cfg_pkg::CFG_B] & pins.adapter_b_resistance; // RQ5
      amask = cur.cfg[phy_cfg_pkg::CFG_A] & pins.adapter_a_resistance; // RQ9

      // edge detection against last cycle's synchronised levels
      open_evt = cur.enable[phy_cfg_pkg::EN_ID_OPEN] & (pins.id_float ^ cur.pins_q.id_float); // RQ14
      res_evt  = cur.enable[phy_cfg_pkg::EN_ID_RES]
               & ((pins.adapter_a_resistance | pins.adapter_b_resistance)
               ^ (cur.pins_q.adapter_a_resistance | cur.pins_q.adapter_b_resistance));
      events = 6'h00;
      events[phy_cfg_pkg::IRQ_ID_OPEN]   = open_evt;
      events[phy_cfg_pkg::IRQ_ID_RES]    = res_evt;
      // vbus edges by direction
      events[phy_cfg_pkg::IRQ_VBUS_RISE] = cur.enable[phy_cfg_pkg::EN_VBUS_RISE]
                                         & pins.vbus_monitor & ~cur.pins_q.vbus_monitor;
      events[phy_cfg_pkg::IRQ_VBUS_FALL] = cur.enable[phy_cfg_pkg::EN_VBUS_FALL]
                                         & ~pins.vbus_monitor & cur.pins_q.vbus_monitor;
      // battery change either way
      events[phy_cfg_pkg::IRQ_BATT]      = cur.enable[phy_cfg_pkg::EN_BATT]
                                         & (pins.battery_monitor ^ cur.pins_q.battery_monitor);
      // timer expiry, rise only
      events[phy_cfg_pkg::IRQ_SESS_TMR]  = cur.enable[phy_cfg_pkg::EN_SESS_TMR]
                                         & pins.session_timer_timeout & ~cur.pins_q.session_timer_timeout;

      // a new event beats a clear in the same cycle
      next_state.irq_status = (cur.irq_status & ~clr_bits) | events;
      next_state.irq        = |(next_state.irq_status & next_state.irq_mask);
      next_state.pins_q     = pins;

      // report bits; masking also hides VBUS changes from the link
      rep.a_side_vbus_valid = pins.a_side_vbus_valid & ~bmask; // RQ6 RQ8
      rep.session_valid     = pins.session_valid & ~bmask;     // RQ6 RQ8
      rep.id_grounded       = pins.id_grounded | amask;        // RQ9 RQ11
      rep.alt_int           = cur.enable[phy_cfg_pkg::EN_ID_RES]
                            & (pins.adapter_a_resistance | pins.adapter_b_resistance); // RQ15
      next_state.report     = rep;

      // any visible change, or an enabled ID event, sends a command
      next_state.rxcmd_send = (rep != cur.report) | open_evt | res_evt; // RQ14 RQ15

      // stored charge commands untouched; only the pulls are gated
      next_state.srp_pullup   = link_cmd.vbus_charge_cmd & ~bmask;    // RQ7
      next_state.srp_pulldown = link_cmd.vbus_discharge_cmd & ~bmask; // RQ7

      // charger already supplies VBUS, so do not fight it
      next_state.power_switch_out = link_cmd.drive_vbus_cmd & ~amask; // RQ10 RQ11

      // frame clock: half a period per SOF, parked low when off
      if (!cur.cfg[phy_cfg_pkg::CFG_SOF]) begin
         next_state.sof_clock_out = 1'b0; // RQ12
      end else if (link_cmd.hs_sof_strobe) begin
         next_state.sof_clock_out = ~cur.sof_clock_out; // RQ13
      end
      // pulse one edge after K
      next_state.resume_start = cur.enable[phy_cfg_pkg::EN_RESUME] & link_cmd.resume_k_detect; // RQ16
   end

   // single state register
   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         // constants only
         cur                  <= '0;
         cur.waitrequest      <= 1'b1;
         cur.enable           <= phy_cfg_pkg::EN_RESET;
         cur.cfg              <= phy_cfg_pkg::CFG_RESET; // RQ4
         cur.irq_status       <= phy_cfg_pkg::IRQ_RESET;
         cur.irq_mask         <= phy_cfg_pkg::IRQ_RESET;
      end else begin
         cur <= next_state;
      end
   end

   // outputs straight from the state register
   // bus answers
   assign avs_readdata          = cur.readdata;
   assign avs_waitrequest       = cur.waitrequest;

   // link and pin side
   assign rxcmd_report          = cur.report;
   assign rxcmd_send            = cur.rxcmd_send;
   assign srp_pullup            = cur.srp_pullup;
   assign srp_pulldown          = cur.srp_pulldown;
   assign power_switch_out      = cur.power_switch_out;
   assign sof_clock_out         = cur.sof_clock_out;
   assign resume_watchdog_start = cur.resume_start;
   assign irq                   = cur.irq;

   // checks on the registered behaviour
   // single clock domain
   default clocking cb @(posedge ref_clk);
   endclocking
   default disable iff (!rstn);

   // antecedent now, consequent next edge, except the readback and irq checks, which hold in the same cycle
   // set ORs ones in
   chk_set_write: assert property (wr_take && reg_index(avs_address) == phy_cfg_pkg::IDX_EN_SET // RQ1
      |=> cur.enable == ($past(cur.enable) | ($past(avs_writedata[7:0]) & 8'h7F)))
      else $error("enable set write wrong");

   // clear drops ones, bit 7 stays 0
   chk_clear_write: assert property (wr_take && reg_index(avs_address) == phy_cfg_pkg::IDX_EN_CLR // RQ2
      |=> cur.enable == ($past(cur.enable) & ~$past(avs_writedata[7:0])) && !cur.enable[7])
      else $error("enable clear write wrong");

   // clear view reads the enable
   chk_read_enable: assert property (avs_read && !avs_waitrequest // RQ3
      && reg_index(avs_address) == phy_cfg_pkg::IDX_EN_CLR |-> avs_readdata == {24'h000000, cur.enable})
      else $error("enable readback wrong");

   // config byte stored whole
   chk_cfg_write: assert property (wr_take && reg_index(avs_address) == phy_cfg_pkg::IDX_CFG // RQ4
      |=> cur.cfg == $past(avs_writedata[7:0]))
      else $error("config write lost");

   // B condition hides VBUS state
   chk_b_report: assert property (bmask |=> !rxcmd_report.a_side_vbus_valid // RQ6
      && !rxcmd_report.session_valid)
      else $error("vbus valid leaked in B mode");

   // B condition kills both pulls
   chk_srp_off: assert property (bmask |=> !srp_pullup && !srp_pulldown) // RQ7
      else $error("srp pull active in B mode");

   // B config off: session passes
   chk_b_pass: assert property (!cur.cfg[phy_cfg_pkg::CFG_B] // RQ8
      |=> rxcmd_report.session_valid == $past(pins.session_valid))
      else $error("session valid altered");

   // A condition reports grounded
   chk_a_id_grounded: assert property (amask |=> rxcmd_report.id_grounded) // RQ9
      else $error("id not grounded in A mode");

   // A condition drops the switch
   chk_psw_off: assert property (amask |=> !power_switch_out) // RQ10
      else $error("power switch on in A mode");

   // A config off: switch follows
   chk_a_pass: assert property (!cur.cfg[phy_cfg_pkg::CFG_A] // RQ11
      |=> power_switch_out == $past(link_cmd.drive_vbus_cmd))
      else $error("power switch altered");

   // parked low when disabled
   chk_sof_off: assert property (!cur.cfg[phy_cfg_pkg::CFG_SOF] |=> !sof_clock_out) // RQ12
      else $error("frame clock while disabled");

   // one toggle per SOF strobe
   chk_sof_toggle: assert property (cur.cfg[phy_cfg_pkg::CFG_SOF] && link_cmd.hs_sof_strobe // RQ13
      |=> sof_clock_out != $past(sof_clock_out))
      else $error("frame clock missed toggle");

   // ID float edge sends command
   chk_open_rxcmd: assert property (open_evt |=> rxcmd_send) // RQ14
      else $error("no command on id float edge");

   // resistor change carries alt_int
   chk_alt_int: assert property (res_evt && rep.alt_int |=> rxcmd_send && rxcmd_report.alt_int) // RQ15
      else $error("alt_int command missing");

   // watchdog start follows enable
   chk_wdog_start: assert property (link_cmd.resume_k_detect // RQ16
      |=> resume_watchdog_start == $past(cur.enable[phy_cfg_pkg::EN_RESUME]))
      else $error("watchdog start wrong");

   // level follows unmasked status
   chk_irq_level: assert property (|(cur.irq_status & cur.irq_mask) |-> irq)
      else $error("interrupt not raised");

   // no cause, no interrupt
   chk_irq_quiet: assert property (!(|(cur.irq_status & cur.irq_mask)) |-> !irq)
      else $error("interrupt without cause");

   cov_b_adapter: cover property (bmask ##1 rxcmd_send);
   cov_sof_run: cover property (cur.cfg[phy_cfg_pkg::CFG_SOF] && link_cmd.hs_sof_strobe);
   cov_irq_clear: cover property (irq ##1 wr_take ##1 !irq);
   cov_a_adapter: cover property (amask ##1 !power_switch_out);
   cov_float_event: cover property (open_evt ##1 rxcmd_send);

endmodule : adapter_frame_regs

// ===== sim/link_model.sv
`timescale 1ns/100ps
// stand-in for the link controller: drives commands and strobes, logs receive commands
module link_model (
   input  wire logic                       ref_clk,
   input  wire logic                       rstn,
   input  wire phy_cfg_pkg::rxcmd_report_t rxcmd_report,
   input  wire logic                       rxcmd_send,
   output phy_cfg_pkg::link_cmd_t          link_cmd
);
   int                         rx_cnt;  // receive commands seen
   phy_cfg_pkg::rxcmd_report_t last_rx; // latest receive command contents

   initial link_cmd = '0;

   // capture on the edge where the send pulse stands; it lasts one cycle only
   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         rx_cnt  <= 0;
         last_rx <= '0;
      end else if (rxcmd_send === 1'b1) begin
         rx_cnt  <= rx_cnt + 1;
         last_rx <= rxcmd_report;
      end
   end

   // command levels change just after an edge, as a real link would
   task automatic set_cmd(input logic chg, input logic dis, input logic drv);
      link_cmd.vbus_charge_cmd    <= chg;
      link_cmd.vbus_discharge_cmd <= dis;
      link_cmd.drive_vbus_cmd     <= drv;
   endtask : set_cmd

   // one-cycle strobe then a gap; a long gap plays a slow link
   task automatic strobe(input logic sof, input int gap);
      if (sof) link_cmd.hs_sof_strobe <= 1'b1;
      else link_cmd.resume_k_detect <= 1'b1;
      @(posedge ref_clk);
      link_cmd.hs_sof_strobe   <= 1'b0;
      link_cmd.resume_k_detect <= 1'b0;
      repeat (gap) @(posedge ref_clk);
   endtask : strobe
endmodule : link_model

// ===== sim/aca_sof_config_and_irq_enables_bench.sv
`timescale 1ns/100ps
// self-checking bench for the adapter, frame clock and enable registers
module aca_sof_config_and_irq_enables_bench;
   localparam logic [7:0] SET = phy_cfg_pkg::IDX_EN_SET;
   localparam logic [7:0] CLR = phy_cfg_pkg::IDX_EN_CLR;
   localparam logic [7:0] CFG = phy_cfg_pkg::IDX_CFG;
   localparam logic [7:0] STA = phy_cfg_pkg::IDX_IRQ_STAT;
   localparam logic [7:0] MSK = phy_cfg_pkg::IDX_IRQ_MASK;
   logic                       ref_clk = 1'b0;
   logic                       rstn = 1'b0;
   logic [9:0]                 avs_address = '0;
   logic                       avs_read = 1'b0;
   logic                       avs_write = 1'b0;
   logic [31:0]                avs_writedata = '0;
   logic [31:0]                avs_readdata;
   logic                       avs_waitrequest;
   phy_cfg_pkg::detect_pins_t  pins = '0;     // analog detector levels
   phy_cfg_pkg::link_cmd_t     link_cmd;
   phy_cfg_pkg::rxcmd_report_t rep;
   logic                       rxcmd_send, srp_pullup, srp_pulldown, power_switch_out;
   logic                       sof_clock_out, resume_watchdog_start, irq;
   int                         error_cnt = 0;
   int                         n_compared = 0;
   int                         seed = 32'hA0D2;
   int                         wd_cnt = 0;    // watchdog start pulses
   int                         en_m, cfg_m, n0; // model of enable and config
   logic [31:0]                v, q;

   always #5 ref_clk = ~ref_clk;

   adapter_frame_regs u_dut (.ref_clk(ref_clk), .rstn(rstn), .avs_address(avs_address), .avs_read(avs_read),
      .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
      .avs_waitrequest(avs_waitrequest), .detect_pins(pins), .link_cmd(link_cmd), .rxcmd_report(rep),
      .rxcmd_send(rxcmd_send), .srp_pullup(srp_pullup), .srp_pulldown(srp_pulldown),
      .power_switch_out(power_switch_out), .sof_clock_out(sof_clock_out),
      .resume_watchdog_start(resume_watchdog_start), .irq(irq));
   link_model u_link (.ref_clk(ref_clk), .rstn(rstn), .rxcmd_report(rep), .rxcmd_send(rxcmd_send),
      .link_cmd(link_cmd));

   // pulse is one cycle wide, so count it where it stands
   always @(posedge ref_clk) if (resume_watchdog_start === 1'b1) wd_cnt++;

   task automatic conclude;
      $display("compared %0d mismatches %0d", n_compared, error_cnt);
      if (error_cnt == 0 && n_compared > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask : conclude

   task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
      n_compared++;
      if (got !== exp) begin
         error_cnt++;
         $display("Error %s expected %h seen %h", what, exp, got);
      end
   endtask : check

   // one bus access; request held until waitrequest is seen low
   task automatic bus(input logic wr, input logic [7:0] idx, input logic [31:0] d);
      int i;
      avs_address   <= {idx, 2'b00};
      avs_write     <= wr;
      avs_read      <= ~wr;
      avs_writedata <= d;
      for (i = 0; i < 20; i++) begin
         @(posedge ref_clk);
         if (avs_waitrequest === 1'b0) break;
      end
      if (i == 20) begin
         error_cnt++;
         $display("Error waitrequest expected 0 seen stuck");
         conclude();
      end
      q = avs_readdata;
      avs_write <= 1'b0;
      avs_read  <= 1'b0;
      @(posedge ref_clk);
   endtask : bus

   task automatic wr(input logic [7:0] idx, input logic [31:0] d);
      bus(1'b1, idx, d);
   endtask : wr

   task automatic rd(input string what, input logic [7:0] idx, input logic [31:0] exp);
      bus(1'b0, idx, 32'h0);
      check(what, exp, q);
   endtask : rd

   // detector path is sync plus one register; six edges is ample
   task automatic settle;
      repeat (6) @(posedge ref_clk);
   endtask : settle

   initial begin
      repeat (20000) @(posedge ref_clk);
      error_cnt++;
      $display("Error run length expected end seen hang");
      conclude();
   end

   initial begin
      repeat (16) @(posedge ref_clk);
      rstn <= 1'b1;
      @(posedge ref_clk);
      en_m = 32'h40;
      rd("enable at set", SET, en_m);
      rd("enable at clear", CLR, en_m);
      rd("config reset", CFG, 32'h0);
      wr(8'hFF, 32'hFFFFFFFF);
      rd("unmapped", 8'hFF, 32'h0);
      $display("test reset_values done");
      // random ones at set, then at clear; bit 7 never sticks
      for (int k = 0; k < 8; k++) begin
         v = $random(seed);
         wr(SET, v);
         en_m = (en_m | v) & 32'h7F;
         rd("enable after set", CLR, en_m);
         v = $random(seed);
         wr(CLR, v);
         en_m = en_m & ~v & 32'h7F;
         rd("enable after clear", SET, en_m);
      end
      for (int k = 0; k < 4; k++) begin
         v = $random(seed);
         wr(CFG, v);
         cfg_m = v & 32'hFF;
         rd("config readback", CFG, cfg_m);
      end
      wr(CFG, 32'h0);
      wr(CLR, 32'h7F);
      $display("test set_clear done");
      // B adapter with config off, then on
      u_link.set_cmd(1'b1, 1'b1, 1'b1);
      pins.a_side_vbus_valid    <= 1'b1;
      pins.session_valid        <= 1'b1;
      pins.adapter_b_resistance <= 1'b1;
      settle();
      check("vbus valid, B off", 1, rep.a_side_vbus_valid);
      check("session, B off", 1, rep.session_valid);
      check("pullup, B off", 1, srp_pullup);
      wr(CFG, 32'h80);
      settle();
      check("vbus valid, B on", 0, rep.a_side_vbus_valid);
      check("session, B on", 0, rep.session_valid);
      check("pullup, B on", 0, srp_pullup);
      check("pulldown, B on", 0, srp_pulldown);
      check("charge cmd kept", 1, link_cmd.vbus_charge_cmd);
      n0 = u_link.rx_cnt;
      pins.a_side_vbus_valid <= 1'b0;
      settle();
      check("hidden vbus change", n0, u_link.rx_cnt);
      pins.adapter_b_resistance <= 1'b0;
      settle();
      check("pulldown, B gone", 1, srp_pulldown);
      wr(CFG, 32'h0);
      pins <= '0;
      settle();
      $display("test adapter_b done");
      // A adapter with resistor events enabled
      wr(SET, 32'h10);
      n0 = u_link.rx_cnt;
      pins.adapter_a_resistance <= 1'b1;
      settle();
      check("rxcmd on rid", 1, u_link.rx_cnt > n0);
      check("alt_int", 1, u_link.last_rx.alt_int);
      check("id grounded, A off", 0, rep.id_grounded);
      check("power switch, A off", 1, power_switch_out);
      wr(CFG, 32'h40);
      settle();
      check("id grounded, A on", 1, rep.id_grounded);
      check("power switch, A on", 0, power_switch_out);
      pins.adapter_a_resistance <= 1'b0;
      settle();
      check("power switch, A gone", 1, power_switch_out);
      wr(CFG, 32'h0);
      wr(CLR, 32'h10);
      $display("test adapter_a done");
      // frame clock: quiet when disabled, toggles per strobe when enabled
      u_link.strobe(1'b1, 3);
      check("frame clock off", 0, sof_clock_out);
      wr(CFG, 32'h20);
      for (int k = 1; k <= 4; k++) begin
         u_link.strobe(1'b1, k + 1);
         check("frame clock level", k % 2, sof_clock_out);
      end
      u_link.strobe(1'b1, 2);
      wr(CFG, 32'h0);
      repeat (2) @(posedge ref_clk);
      check("frame clock disabled", 0, sof_clock_out);
      $display("test frame_clock done");
      // ID float events, sticky status, mask and level interrupt
      wr(STA, 32'h3F);
      wr(SET, 32'h20);
      wr(MSK, 32'h01);
      n0 = u_link.rx_cnt;
      pins.id_float <= 1'b1;
      settle();
      check("rxcmd on float rise", n0 + 1, u_link.rx_cnt);
      check("irq raised", 1, irq);
      pins.id_float <= 1'b0;
      settle();
      check("rxcmd on float fall", n0 + 2, u_link.rx_cnt);
      rd("status sticky", STA, 32'h01);
      wr(STA, 32'h01);
      rd("status cleared", STA, 32'h0);
      check("irq cleared", 0, irq);
      wr(MSK, 32'h0);
      pins.id_float <= 1'b1;
      settle();
      check("irq masked", 0, irq);
      wr(STA, 32'h3F);
      wr(CLR, 32'h20);
      pins.id_float <= 1'b0;
      settle();
      check("no rxcmd when disabled", n0 + 3, u_link.rx_cnt);
      $display("test float_irq done");
      // resume K starts the watchdog only while its enable is set
      wr(SET, 32'h40);
      n0 = wd_cnt;
      u_link.strobe(1'b0, 4);
      check("watchdog start", n0 + 1, wd_cnt);
      wr(CLR, 32'h40);
      u_link.strobe(1'b0, 4);
      check("watchdog disabled", n0 + 1, wd_cnt);
      $display("test resume done");
      conclude();
   end
endmodule : aca_sof_config_and_irq_enables_bench
